// ### design/fcl_pkg.sv
// Constants and encodings for the fabric change lock sequencer
package fcl_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int FCL_SLOTS = 8;
  localparam int SLOT_W    = 3;
  localparam int CUR_W     = 4;
  localparam int ID_W      = 8;
  localparam int IDS_W     = FCL_SLOTS * ID_W;
  localparam int CMD_W     = 8;
  localparam int DATA_W    = 32;
  localparam int REASON_W  = 8;
  localparam int STAT_W    = 3;

  // ****************************************
  // Message kinds
  // ****************************************
  localparam logic [1:0] KIND_ACQUIRE = 2'h0;
  localparam logic [1:0] KIND_STAGE   = 2'h1;
  localparam logic [1:0] KIND_UPDATE  = 2'h2;
  localparam logic [1:0] KIND_RELEASE = 2'h3;

  // ****************************************
  // Reject reasons
  // ****************************************
  localparam logic [REASON_W-1:0] REASON_NONE        = 8'h00;
  localparam logic [REASON_W-1:0] REASON_BUSY        = 8'h01;
  localparam logic [REASON_W-1:0] REASON_FABRIC_CHG  = 8'h02;
  localparam logic [REASON_W-1:0] REASON_UNSUPPORTED = 8'h03;
  localparam logic [REASON_W-1:0] REASON_NOT_HOLDER  = 8'h04;

  // ****************************************
  // Change outcome
  // ****************************************
  localparam logic [STAT_W-1:0] STAT_OK          = 3'h0;
  localparam logic [STAT_W-1:0] STAT_INVALID     = 3'h1;
  localparam logic [STAT_W-1:0] STAT_LOCAL_BUSY  = 3'h2;
  localparam logic [STAT_W-1:0] STAT_ACQ_FAIL    = 3'h3;
  localparam logic [STAT_W-1:0] STAT_STAGE_FAIL  = 3'h4;
  localparam logic [STAT_W-1:0] STAT_UPDATE_FAIL = 3'h5;

  // ****************************************
  // Counts and reset values
  // ****************************************
  localparam logic [CUR_W-1:0]  CUR_FIRST    = 4'h0;
  localparam logic [CUR_W-1:0]  CUR_END      = 4'h8;
  localparam logic [1:0]        RST_SYNC_VAL = 2'h0;
  localparam logic [ID_W-1:0]   ID_NONE      = 8'h00;
  localparam logic [CMD_W-1:0]  CMD_NONE     = 8'h00;
  localparam logic [DATA_W-1:0] DATA_NONE    = 32'h0000_0000;
  localparam logic [IDS_W-1:0]  IDS_NONE     = 64'h0000_0000_0000_0000;

endpackage : fcl_pkg

// ### design/fcl_peer_slot.sv
// Per-domain tracker of authorization and outstanding answer
`timescale 1ns/1ps
`default_nettype none
module fcl_peer_slot (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Phase control
  input  wire logic session_start,
  input  wire logic phase_start,
  input  wire logic is_acquire,
  input  wire logic is_release,
  // Events
  input  wire logic sent,
  input  wire logic resp,
  input  wire logic accept,
  // State
  output logic      pending,
  output logic      granted,
  output logic      failed
);

  // ****************************************
  // Outstanding answer
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pending <= 1'b0;
    end else if (sent) begin
      pending <= 1'b1;
    end else if (resp) begin
      pending <= 1'b0;
    end
  end

  // ****************************************
  // Authorization held for us
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      granted <= 1'b0;
    end else if (resp && accept && is_acquire) begin
      granted <= 1'b1;
    end else if ((resp && is_release) || session_start) begin
      granted <= 1'b0;
    end
  end

  // ****************************************
  // Reject seen in this phase
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      failed <= 1'b0;
    end else if (resp && !accept) begin
      failed <= 1'b1;
    end else if (phase_start) begin
      failed <= 1'b0;
    end
  end

endmodule : fcl_peer_slot
`default_nettype wire

// ### design/fcl_sequencer.sv
// Fabric change lock sequencer: managing side and managed side
`timescale 1ns/1ps
`default_nettype none
module fcl_sequencer
  import fcl_pkg::*;
(
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                reset_n,
  // Change request from management
  input  wire logic                chg_valid,
  input  wire logic [CMD_W-1:0]    chg_cmd,
  input  wire logic [DATA_W-1:0]   chg_data,
  input  wire logic [IDS_W-1:0]    chg_domain_ids,
  input  wire logic [FCL_SLOTS-1:0] chg_domain_mask,
  output logic                     chg_ready,
  output logic                     chg_done,
  output logic [STAT_W-1:0]        chg_status,
  // Outgoing requests to managed switches
  output logic                     msg_tx_valid,
  input  wire logic                msg_tx_ready,
  output logic [SLOT_W-1:0]        msg_tx_slot,
  output logic [ID_W-1:0]          msg_tx_dest,
  output logic [1:0]               msg_tx_kind,
  output logic [CMD_W-1:0]         msg_tx_cmd,
  output logic [DATA_W-1:0]        msg_tx_data,
  output logic [IDS_W-1:0]         msg_tx_ids,
  // Answers from managed switches
  input  wire logic                rsp_rx_valid,
  input  wire logic [SLOT_W-1:0]   rsp_rx_slot,
  input  wire logic [1:0]          rsp_rx_kind,
  input  wire logic                rsp_rx_accept,
  input  wire logic [REASON_W-1:0] rsp_rx_reason,
  // Incoming requests from a managing switch
  input  wire logic                req_rx_valid,
  output logic                     req_rx_ready,
  input  wire logic [ID_W-1:0]     req_rx_src,
  input  wire logic [1:0]          req_rx_kind,
  input  wire logic [IDS_W-1:0]    req_rx_ids,
  input  wire logic [CMD_W-1:0]    req_rx_cmd,
  input  wire logic [DATA_W-1:0]   req_rx_data,
  input  wire logic                req_rx_unsupported,
  input  wire logic [IDS_W-1:0]    known_domain_ids,
  // Answers to the managing switch
  output logic                     rsp_tx_valid,
  input  wire logic                rsp_tx_ready,
  output logic [ID_W-1:0]          rsp_tx_dest,
  output logic [1:0]               rsp_tx_kind,
  output logic                     rsp_tx_accept,
  output logic [REASON_W-1:0]      rsp_tx_reason,
  // Local configuration
  output logic                     local_lock_held,
  output logic                     cfg_apply,
  output logic [CMD_W-1:0]         cfg_cmd,
  output logic [DATA_W-1:0]        cfg_data
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEND,
    ST_WAIT,
    ST_DONE
  } fcl_state_t;

  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rst_sync;
  logic       rst_n;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync <= RST_SYNC_VAL;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_n = rst_sync[1];

  // ****************************************
  // Declarations
  // ****************************************
  fcl_state_t           state;
  logic [1:0]           kind;
  logic [CUR_W-1:0]     cursor;
  logic [CMD_W-1:0]     sess_cmd;
  logic [DATA_W-1:0]    sess_data;
  logic [IDS_W-1:0]     sess_ids;
  logic [FCL_SLOTS-1:0] sess_mask;
  logic                 self_lock;
  logic                 phase_start;
  logic                 session_start;
  logic [FCL_SLOTS-1:0] pending;
  logic [FCL_SLOTS-1:0] granted;
  logic [FCL_SLOTS-1:0] failed;
  logic [FCL_SLOTS-1:0] rsp_hit;
  logic [FCL_SLOTS-1:0] sent_hit;
  logic [FCL_SLOTS-1:0] target;
  logic                 req_valid_ok;
  logic                 tx_fire;
  logic                 req_take;
  logic                 peer_lock;
  logic [ID_W-1:0]      lock_owner;
  logic                 staged;
  logic [CMD_W-1:0]     staged_cmd;
  logic [DATA_W-1:0]    staged_data;
  logic                 holder;
  logic [SLOT_W-1:0]    cur_slot;

  assign tx_fire  = msg_tx_valid && msg_tx_ready;
  assign req_take = req_rx_valid && req_rx_ready;
  assign cur_slot = cursor[SLOT_W-1:0];
  assign holder   = peer_lock && (lock_owner == req_rx_src);

  // ****************************************
  // Request check
  // ****************************************
  always_comb begin
    req_valid_ok = (chg_domain_mask != '0) && (chg_cmd != CMD_NONE);
    for (int i = 0; i < FCL_SLOTS; i++) begin
      if (chg_domain_mask[i] && (chg_domain_ids[i*ID_W +: ID_W] == ID_NONE)) begin
        req_valid_ok = 1'b0;
      end
    end
  end

  // ****************************************
  // Targets of the current phase
  // ****************************************
  assign target = (kind == KIND_RELEASE) ? granted : sess_mask;

  // ****************************************
  // Per-domain trackers
  // ****************************************
  for (genvar g = 0; g < FCL_SLOTS; g++) begin : g_slot
    assign sent_hit[g] = tx_fire && (msg_tx_slot == SLOT_W'(g));
    assign rsp_hit[g]  = rsp_rx_valid && (rsp_rx_slot == SLOT_W'(g))
                         && (rsp_rx_kind == kind) && pending[g];
    fcl_peer_slot u_slot (
      .ref_clk       (ref_clk),
      .rst_n         (rst_n),
      .session_start (session_start),
      .phase_start   (phase_start),
      .is_acquire    (kind == KIND_ACQUIRE),
      .is_release    (kind == KIND_RELEASE),
      .sent          (sent_hit[g]),
      .resp          (rsp_hit[g]),
      .accept        (rsp_rx_accept),
      .pending       (pending[g]),
      .granted       (granted[g]),
      .failed        (failed[g])
    );
  end

  // ****************************************
  // Managing switch phase sequence
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state         <= ST_IDLE;
      kind          <= KIND_ACQUIRE;
      cursor        <= CUR_FIRST;
      phase_start   <= 1'b0;
      session_start <= 1'b0;
      chg_status    <= STAT_OK;
    end else begin
      phase_start   <= 1'b0;
      session_start <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (chg_valid && chg_ready) begin
            if (!req_valid_ok) begin
              chg_status <= STAT_INVALID;
              state      <= ST_DONE;
            end else if (peer_lock || req_take) begin
              chg_status <= STAT_LOCAL_BUSY;
              state      <= ST_DONE;
            end else begin
              chg_status    <= STAT_OK;
              kind          <= KIND_ACQUIRE;
              cursor        <= CUR_FIRST;
              phase_start   <= 1'b1;
              session_start <= 1'b1;
              state         <= ST_SEND;
            end
          end
        end
        ST_SEND: begin
          if (tx_fire) begin
            cursor <= cursor + 4'h1;
          end else if (!msg_tx_valid) begin
            if (cursor == CUR_END) begin
              state <= ST_WAIT;
            end else if (!target[cur_slot]) begin
              cursor <= cursor + 4'h1;
            end
          end
        end
        ST_WAIT: begin
          if (pending == '0) begin
            cursor      <= CUR_FIRST;
            phase_start <= 1'b1;
            state       <= ST_SEND;
            unique case (kind)
              KIND_ACQUIRE: begin
                if (failed != '0) begin
                  chg_status <= STAT_ACQ_FAIL;
                  kind       <= KIND_RELEASE;
                end else begin
                  kind <= KIND_STAGE;
                end
              end
              KIND_STAGE: begin
                if (failed != '0) begin
                  chg_status <= STAT_STAGE_FAIL;
                  kind       <= KIND_RELEASE;
                end else begin
                  kind <= KIND_UPDATE;
                end
              end
              KIND_UPDATE: begin
                if (failed != '0) begin
                  chg_status <= STAT_UPDATE_FAIL;
                end
                kind <= KIND_RELEASE;
              end
              KIND_RELEASE: begin
                phase_start <= 1'b0;
                state       <= ST_DONE;
              end
            endcase
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Session capture
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sess_cmd  <= CMD_NONE;
      sess_data <= DATA_NONE;
      sess_ids  <= IDS_NONE;
      sess_mask <= '0;
    end else if (state == ST_IDLE && chg_valid && chg_ready && req_valid_ok) begin
      sess_cmd  <= chg_cmd;
      sess_data <= chg_data;
      sess_ids  <= chg_domain_ids;
      sess_mask <= chg_domain_mask;
    end
  end

  // ****************************************
  // Management handshake
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      chg_ready <= 1'b0;
      chg_done  <= 1'b0;
    end else begin
      chg_done <= (state == ST_DONE);
      if (state == ST_IDLE && chg_valid && chg_ready) begin
        chg_ready <= 1'b0;
      end else if (state == ST_IDLE) begin
        chg_ready <= 1'b1;
      end
    end
  end

  // ****************************************
  // Own local authorization
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      self_lock <= 1'b0;
    end else if (session_start) begin
      self_lock <= 1'b1;
    end else if (state == ST_DONE) begin
      self_lock <= 1'b0;
    end
  end

  // ****************************************
  // Outgoing request
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      msg_tx_valid <= 1'b0;
      msg_tx_slot  <= '0;
      msg_tx_dest  <= ID_NONE;
      msg_tx_kind  <= KIND_ACQUIRE;
      msg_tx_cmd   <= CMD_NONE;
      msg_tx_data  <= DATA_NONE;
      msg_tx_ids   <= IDS_NONE;
    end else if (tx_fire) begin
      msg_tx_valid <= 1'b0;
    end else if (state == ST_SEND && !msg_tx_valid && cursor != CUR_END
                 && target[cur_slot]) begin
      msg_tx_valid <= 1'b1;
      msg_tx_slot  <= cur_slot;
      msg_tx_dest  <= sess_ids[cur_slot*ID_W +: ID_W];
      msg_tx_kind  <= kind;
      msg_tx_ids   <= (kind == KIND_ACQUIRE) ? sess_ids : IDS_NONE;
      msg_tx_cmd   <= (kind == KIND_STAGE) ? sess_cmd : CMD_NONE;
      msg_tx_data  <= (kind == KIND_STAGE) ? sess_data : DATA_NONE;
    end
  end

  // ****************************************
  // Managed switch answers
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_rx_ready  <= 1'b0;
      rsp_tx_valid  <= 1'b0;
      rsp_tx_dest   <= ID_NONE;
      rsp_tx_kind   <= KIND_ACQUIRE;
      rsp_tx_accept <= 1'b0;
      rsp_tx_reason <= REASON_NONE;
    end else if (rsp_tx_valid) begin
      if (rsp_tx_ready) begin
        rsp_tx_valid <= 1'b0;
        req_rx_ready <= 1'b1;
      end
    end else if (req_take) begin
      req_rx_ready  <= 1'b0;
      rsp_tx_valid  <= 1'b1;
      rsp_tx_dest   <= req_rx_src;
      rsp_tx_kind   <= req_rx_kind;
      rsp_tx_accept <= 1'b1;
      rsp_tx_reason <= REASON_NONE;
      unique case (req_rx_kind)
        KIND_ACQUIRE: begin
          if (req_rx_ids != known_domain_ids) begin
            rsp_tx_accept <= 1'b0;
            rsp_tx_reason <= REASON_FABRIC_CHG;
          end else if (self_lock || (peer_lock && !holder)) begin
            rsp_tx_accept <= 1'b0;
            rsp_tx_reason <= REASON_BUSY;
          end
        end
        KIND_STAGE: begin
          if (!holder) begin
            rsp_tx_accept <= 1'b0;
            rsp_tx_reason <= REASON_NOT_HOLDER;
          end else if (req_rx_unsupported) begin
            rsp_tx_accept <= 1'b0;
            rsp_tx_reason <= REASON_UNSUPPORTED;
          end
        end
        KIND_UPDATE: begin
          if (!holder || !staged) begin
            rsp_tx_accept <= 1'b0;
            rsp_tx_reason <= REASON_NOT_HOLDER;
          end
        end
        KIND_RELEASE: begin
          if (!holder) begin
            rsp_tx_accept <= 1'b0;
            rsp_tx_reason <= REASON_NOT_HOLDER;
          end
        end
      endcase
    end else begin
      req_rx_ready <= 1'b1;
    end
  end

  // ****************************************
  // Local change authorization and staging
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      peer_lock   <= 1'b0;
      lock_owner  <= ID_NONE;
      staged      <= 1'b0;
      staged_cmd  <= CMD_NONE;
      staged_data <= DATA_NONE;
    end else if (req_take) begin
      unique case (req_rx_kind)
        KIND_ACQUIRE: begin
          if (req_rx_ids == known_domain_ids && !self_lock && (!peer_lock || holder)) begin
            peer_lock  <= 1'b1;
            lock_owner <= req_rx_src;
          end
        end
        KIND_STAGE: begin
          if (holder && !req_rx_unsupported) begin
            staged      <= 1'b1;
            staged_cmd  <= req_rx_cmd;
            staged_data <= req_rx_data;
          end
        end
        KIND_UPDATE: begin
          if (holder) begin
            staged <= 1'b0;
          end
        end
        KIND_RELEASE: begin
          if (holder) begin
            peer_lock <= 1'b0;
            staged    <= 1'b0;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Apply staged configuration
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_apply       <= 1'b0;
      cfg_cmd         <= CMD_NONE;
      cfg_data        <= DATA_NONE;
      local_lock_held <= 1'b0;
    end else begin
      local_lock_held <= peer_lock || self_lock;
      cfg_apply       <= req_take && (req_rx_kind == KIND_UPDATE) && holder && staged;
      if (req_take && (req_rx_kind == KIND_UPDATE) && holder && staged) begin
        cfg_cmd  <= staged_cmd;
        cfg_data <= staged_data;
      end
    end
  end

endmodule : fcl_sequencer
`default_nettype wire

// ### verification/fcl_assertions.sv
// Port checks for the sequencer
`timescale 1ns/1ps
`default_nettype none
module fcl_assertions
  import fcl_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              reset_n,
  input wire logic              chg_valid,
  input wire logic              chg_ready,
  input wire logic              chg_done,
  input wire logic [STAT_W-1:0] chg_status,
  input wire logic              msg_tx_valid,
  input wire logic              msg_tx_ready,
  input wire logic [SLOT_W-1:0] msg_tx_slot,
  input wire logic [ID_W-1:0]   msg_tx_dest,
  input wire logic [1:0]        msg_tx_kind,
  input wire logic [CMD_W-1:0]  msg_tx_cmd,
  input wire logic [DATA_W-1:0] msg_tx_data,
  input wire logic [IDS_W-1:0]  msg_tx_ids,
  input wire logic              req_rx_valid,
  input wire logic              req_rx_ready,
  input wire logic [1:0]        req_rx_kind,
  input wire logic [IDS_W-1:0]  req_rx_ids,
  input wire logic              req_rx_unsupported,
  input wire logic [IDS_W-1:0]  known_domain_ids,
  input wire logic              rsp_tx_valid,
  input wire logic              rsp_tx_accept,
  input wire logic [7:0]        rsp_tx_reason
);
  // ****
  // Sequences
  // ****
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence s_take;
    chg_valid && chg_ready;
  endsequence
  sequence s_invalid;
    s_take ##1 chg_status == STAT_INVALID;
  endsequence
  sequence s_req;
    req_rx_valid && req_rx_ready;
  endsequence
  // ****
  // Checks
  // ****
  chk_take_ready: assert property (s_take |=> !chg_ready)
    else $error("ready high after take");
  chk_invalid_done: assert property (s_invalid |-> ##[0:3] chg_done)
    else $error("invalid change not ended");
  chk_done_pulse: assert property (chg_done |-> !chg_ready ##1 (chg_ready && !chg_done))
    else $error("done not a pulse");
  chk_msg_hold: assert property (msg_tx_valid && !msg_tx_ready |=>
    msg_tx_valid && $stable(msg_tx_dest) && $stable(msg_tx_kind))
    else $error("request changed while waiting");
  chk_acq_dest: assert property (msg_tx_valid && msg_tx_kind == KIND_ACQUIRE
    |-> msg_tx_dest == msg_tx_ids[msg_tx_slot*8+:8] && msg_tx_dest != ID_NONE)
    else $error("acquire list or target wrong");
  chk_stage_cmd: assert property (msg_tx_valid && msg_tx_kind == KIND_STAGE
    |-> msg_tx_cmd != CMD_NONE && msg_tx_ids == IDS_NONE)
    else $error("stage without command");
  chk_empty_payload: assert property (msg_tx_valid && msg_tx_kind[1]
    |-> msg_tx_data == DATA_NONE && msg_tx_cmd == CMD_NONE)
    else $error("payload on update or release");
  chk_reply_next: assert property (s_req |=> rsp_tx_valid && !req_rx_ready)
    else $error("no answer after request");
  chk_fabric_chg: assert property (req_rx_valid && req_rx_ready
    && req_rx_kind == KIND_ACQUIRE && req_rx_ids != known_domain_ids
    |=> !rsp_tx_accept && rsp_tx_reason == REASON_FABRIC_CHG)
    else $error("list mismatch not rejected");
  chk_unsupported: assert property (req_rx_valid && req_rx_ready
    && req_rx_kind == KIND_STAGE && req_rx_unsupported |=> !rsp_tx_accept)
    else $error("unsupported stage accepted");
endmodule : fcl_assertions
bind fcl_sequencer fcl_assertions u_chk (.*);
`default_nettype wire

// ### verification/fcl_peer_model.sv
// Managed switches answering the sequencer
`timescale 1ns/1ps
`default_nettype none
module fcl_peer_model
  import fcl_pkg::*;
(
  input wire logic                 ref_clk,
  input wire logic                 stall,
  input wire logic [31:0]          rej,
  input wire logic                 msg_tx_valid,
  output logic                     msg_tx_ready,
  input wire logic [SLOT_W-1:0]    msg_tx_slot,
  input wire logic [1:0]           msg_tx_kind,
  output logic                     rsp_rx_valid,
  output logic [SLOT_W-1:0]        rsp_rx_slot,
  output logic [1:0]               rsp_rx_kind,
  output logic                     rsp_rx_accept,
  output logic [REASON_W-1:0]      rsp_rx_reason
);
  always_ff @(posedge ref_clk) begin
    msg_tx_ready <= !stall || !msg_tx_ready;
    rsp_rx_valid <= msg_tx_valid && msg_tx_ready;
    if (msg_tx_valid && msg_tx_ready) begin
      rsp_rx_slot   <= msg_tx_slot;
      rsp_rx_kind   <= msg_tx_kind;
      rsp_rx_accept <= !rej[{msg_tx_kind, msg_tx_slot}];
      rsp_rx_reason <= rej[{msg_tx_kind, msg_tx_slot}] ? REASON_BUSY : REASON_NONE;
    end else begin
      rsp_rx_slot   <= ~rsp_rx_slot;
      rsp_rx_kind   <= ~rsp_rx_kind;
      rsp_rx_accept <= ~rsp_rx_accept;
      rsp_rx_reason <= ~rsp_rx_reason;
    end
  end
endmodule : fcl_peer_model
`default_nettype wire

// ### verification/test_fabric_change_lock_sequencer.sv
// Bench for the fabric change lock sequencer
`timescale 1ns/1ps
`default_nettype none
module test_fabric_change_lock_sequencer;
  import fcl_pkg::*;
  logic ref_clk, reset_n, chg_valid, chg_ready, chg_done, stall, cfg_apply, local_lock_held;
  logic msg_tx_valid, msg_tx_ready, rsp_rx_valid, rsp_rx_accept, req_rx_valid, req_rx_ready;
  logic req_rx_unsupported, rsp_tx_valid, rsp_tx_ready, rsp_tx_accept;
  logic [1:0] msg_tx_kind, rsp_rx_kind, req_rx_kind, rsp_tx_kind;
  logic [2:0] chg_status, msg_tx_slot, rsp_rx_slot;
  logic [7:0] chg_cmd, chg_domain_mask, msg_tx_dest, msg_tx_cmd, rsp_rx_reason, req_rx_src;
  logic [7:0] req_rx_cmd, rsp_tx_dest, rsp_tx_reason, cfg_cmd;
  logic [31:0] chg_data, msg_tx_data, req_rx_data, cfg_data, rej;
  logic [63:0] chg_domain_ids, msg_tx_ids, req_rx_ids, known_domain_ids;
  int failures, n_compared, cyc, e, seed = 61658;
  int q[$];
  fcl_sequencer dut (.*);
  fcl_peer_model peer (.*);
  initial begin
    ref_clk = 0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic stop_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic cmp(input logic [127:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : cmp
  // ****
  // Outgoing request model
  // ****
  always @(negedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      stop_test();
    end
    if (msg_tx_valid && msg_tx_ready) begin
      e = q.size() ? q.pop_front() : 99;
      cmp({msg_tx_kind, msg_tx_slot, msg_tx_dest, msg_tx_cmd, msg_tx_data, msg_tx_ids},
        {e[4:3], e[2:0], chg_domain_ids[e[2:0]*8+:8], e[4:3] == 1 ? chg_cmd : 8'h00,
        e[4:3] == 1 ? chg_data : 32'h0, e[4:3] == 0 ? chg_domain_ids : 64'h0});
    end
  end
  task automatic push(input int k, input logic [7:0] m);
    for (int i = 0; i < 8; i++)
      if (m[i]) q.push_back(k * 8 + i);
  endtask : push
  // Change with reject at lowest slot: 0..2 phase, 3 none, 4 invalid, 5 locked
  task automatic change(input logic [7:0] m, input int rk);
    int s;
    logic [2:0] st;
    s = 0;
    while (!m[s]) s++;
    rej = 0;
    if (rk < 3) rej[rk*8+s] = 1;
    stall = $random(seed);
    st = rk == 4 ? STAT_INVALID : STAT_LOCAL_BUSY;
    if (rk < 4) begin
      push(0, m);
      if (rk == 0) m[s] = 0;
      else push(1, m);
      if (rk > 1) push(2, m);
      push(3, m);
      st = rk == 0 ? STAT_ACQ_FAIL : rk == 1 ? STAT_STAGE_FAIL : rk == 2 ? STAT_UPDATE_FAIL : STAT_OK;
    end
    @(negedge ref_clk);
    chg_valid = 1;
    chg_domain_mask = m | rej[7:0] | rej[15:8] | rej[23:16];
    chg_cmd = rk == 4 ? 8'h00 : $random(seed) | 1;
    chg_data = $random(seed);
    chg_domain_ids = {$random(seed), $random(seed)} | 64'h0101010101010101;
    while (chg_ready !== 1'b1) @(negedge ref_clk);
    @(negedge ref_clk);
    chg_valid = 0;
    while (chg_done !== 1'b1) @(negedge ref_clk);
    cmp(chg_status, st);
    cmp(q.size(), 0);
    $display("change test %0d done", rk);
  endtask : change
  // ****
  // Managed side
  // ****
  task automatic req(input logic [1:0] k, input logic [7:0] s, input logic b, u, ok,
    input logic [7:0] why);
    @(negedge ref_clk);
    req_rx_valid = 1;
    req_rx_kind = k;
    req_rx_src = s;
    req_rx_ids = b ? ~known_domain_ids : known_domain_ids;
    req_rx_unsupported = u;
    if (k == 1) req_rx_cmd = $random(seed);
    if (k == 1) req_rx_data = $random(seed);
    while (req_rx_ready !== 1'b1) @(negedge ref_clk);
    @(negedge ref_clk);
    req_rx_valid = 0;
    cmp({rsp_tx_valid, rsp_tx_dest, rsp_tx_kind, rsp_tx_accept, rsp_tx_reason, cfg_apply},
      {1'b1, s, k, ok, why, k == 2 && ok});
    rsp_tx_ready = 1;
    @(negedge ref_clk);
    rsp_tx_ready = 0;
    $display("request test %0d done", k);
  endtask : req
  initial begin
    {chg_valid, chg_cmd, chg_data, chg_domain_ids, chg_domain_mask, req_rx_valid} = 0;
    {req_rx_src, req_rx_kind, req_rx_ids, req_rx_cmd, req_rx_data, req_rx_unsupported} = 0;
    {rsp_tx_ready, rej, stall} = 0;
    known_domain_ids = {$random(seed), $random(seed)};
    reset_n = 0;
    repeat (8) @(negedge ref_clk);
    reset_n = 1;
    change(8'hFF, 3);
    for (int r = 0; r < 15; r++)
      change($random(seed) | (8'h01 << (r % 8)), r % 5);
    req(0, 8'h11, 1, 0, 0, REASON_FABRIC_CHG);
    req(0, 8'h11, 0, 0, 1, REASON_NONE);
    cmp(local_lock_held, 1);
    req(0, 8'h22, 0, 0, 0, REASON_BUSY);
    change(8'h01, 5);
    req(1, 8'h11, 0, 1, 0, REASON_UNSUPPORTED);
    req(1, 8'h11, 0, 0, 1, REASON_NONE);
    req(2, 8'h11, 0, 0, 1, REASON_NONE);
    cmp({cfg_cmd, cfg_data}, {req_rx_cmd, req_rx_data});
    req(3, 8'h11, 0, 0, 1, REASON_NONE);
    cmp(local_lock_held, 0);
    req(2, 8'h11, 0, 0, 0, REASON_NOT_HOLDER);
    req(3, 8'h22, 0, 0, 0, REASON_NOT_HOLDER);
    stop_test();
  end
endmodule : test_fabric_change_lock_sequencer
`default_nettype wire
